// >>> hw/adcr_ctrl.sv
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "adcr_regs.svh"
module adcr_ctrl
    import adcr_pkg::*;
#(
    parameter int CONV_CYCLES = `ADCR_CONV_CYCLES
)(
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    input  wire logic [1:0]         addr_i,
    input  wire logic [7:0]         wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic [7:0]              rdata_o,
    input  wire logic [9:0]         core_data_i,
    output adcr_analog_s            analog_o,
    output logic [3:0]              pin_select_o,
    output logic                    done_irq_o,
    output logic                    conv_clk_en_o
);
    initial
    begin
        if (CONV_CYCLES < 1 || CONV_CYCLES > 255)
            $error("conversion cycle count out of range");
    end

    adcr_ctrl_a_s ctrl_a;              // control a
    adcr_ctrl_b_s ctrl_b;              // control b
    logic [9:0]   result;              // raw result
    adcr_state_e  state;               // sequencer
    logic [6:0]   div_cnt;             // prescaler
    logic [7:0]   conv_cnt;            // converter clocks
    logic         irq_flag;            // end of conversion pulse

    // prescaler terminal: all bits below 2^code are ones
    function automatic logic tick_of(input logic [6:0] cnt, input logic [2:0] code);
        logic [6:0] mask;
        mask = 7'((8'h01 << code) - 8'h01);
        return (cnt & mask) == mask;
    endfunction

    wire       wr_a       = wr_i && addr_i == `ADCR_ADDR_CTRL_A;
    wire       wr_b       = wr_i && addr_i == `ADCR_ADDR_CTRL_B;
    // start seen as a falling written bit after a high one
    wire       start_fall = wr_a && ctrl_a.start && !wdata_i[`ADCR_A_START];
    wire       adc_tick   = tick_of(div_cnt, ctrl_b.div);
    wire       conv_last  = adc_tick && conv_cnt == 8'(CONV_CYCLES - 1);
    // alignment of the stored result
    wire [7:0] res_lo     = ctrl_a.align ? result[7:0]
                                         : {result[1:0], 6'h00};
    wire [7:0] res_hi     = ctrl_a.align ? {6'h00, result[9:8]}
                                         : result[9:2];
    // read mux, results never written
    wire [7:0] next_rdata = addr_i == `ADCR_ADDR_RES_LO ? res_lo :
                            addr_i == `ADCR_ADDR_RES_HI ? res_hi :
                            addr_i == `ADCR_ADDR_CTRL_A ? 8'(ctrl_a) : 8'(ctrl_b);
    // channel codes 4..7 select no pin
    wire [3:0] next_pins  = (ctrl_b.src == 2'h0 && !ctrl_a.chan[2])
                            ? 4'(8'h01 << ctrl_a.chan[1:0]) : 4'h0;

    // control registers; busy is hardware-owned
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ctrl_a <= `ADCR_CTRL_RESET;
            ctrl_b <= `ADCR_CTRL_RESET;
        end
        else
        begin
            if (wr_a)
            begin
                ctrl_a <= wdata_i;
                // a start is only taken from idle, so busy may not rise elsewhere
                ctrl_a.busy <= (state == ADCR_CONV)
                               || (state == ADCR_IDLE && start_fall && ctrl_a.enable);
            end
            else if (state == ADCR_LATCH)
                ctrl_a.busy <= 1'b0;
            if (wr_b)
                ctrl_b <= wdata_i;
        end
    end

    // prescaler, runs only when enabled and out of idle to save power
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            div_cnt <= 7'h00;
        else if (!ctrl_a.enable || state == ADCR_IDLE)
            div_cnt <= 7'h00;
        else
            div_cnt <= div_cnt + 7'h01;
    end

    // conversion sequencer
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state    <= ADCR_IDLE;
            conv_cnt <= 8'h00;
            result   <= 10'h000;
            irq_flag <= 1'b0;
        end
        else
        begin
            irq_flag <= 1'b0;
            case (state)
                ADCR_IDLE:
                begin
                    conv_cnt <= 8'h00;
                    if (start_fall && ctrl_a.enable)
                        state <= ADCR_CONV;
                end
                ADCR_CONV:
                begin
                    if (!ctrl_a.enable)
                        state <= ADCR_LATCH;
                    else if (conv_last)
                    begin
                        result   <= core_data_i;
                        irq_flag <= 1'b1;
                        state    <= ADCR_LATCH;
                    end
                    else if (adc_tick)
                        conv_cnt <= conv_cnt + 8'h01;
                end
                ADCR_LATCH:
                    state <= ADCR_IDLE;
                default:
                    state <= ADCR_IDLE;
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_o       <= 8'h00;
            analog_o      <= '0;
            pin_select_o  <= 4'h0;
            done_irq_o    <= 1'b0;
            conv_clk_en_o <= 1'b0;
        end
        else
        begin
            rdata_o               <= rd_i ? next_rdata : 8'h00;
            analog_o.power_on     <= ctrl_a.enable;
            // no sampling once power is dropped, even in the abort cycle
            analog_o.sample       <= state == ADCR_CONV && ctrl_a.enable;
            analog_o.src          <= ctrl_b.src;
            analog_o.gain         <= {ctrl_b.gain_hi, ctrl_a.gain_lo};
            analog_o.vref_sel     <= ctrl_b.vref_sel;
            analog_o.pin_analog   <= next_pins;
            pin_select_o          <= next_pins;
            done_irq_o            <= irq_flag;
            conv_clk_en_o         <= adc_tick && state == ADCR_CONV;
        end
    end
endmodule

// >>> hw/adcr_regs.svh
`ifndef ADCR_REGS_SVH
`define ADCR_REGS_SVH
// register indices, our choice
`define ADCR_ADDR_RES_LO   2'h0
`define ADCR_ADDR_RES_HI   2'h1
`define ADCR_ADDR_CTRL_A   2'h2
`define ADCR_ADDR_CTRL_B   2'h3
// control a fields
`define ADCR_A_START       7
`define ADCR_A_BUSY        6
`define ADCR_A_ENABLE      5
`define ADCR_A_ALIGN       4
`define ADCR_A_GAIN_LO     3
// control b fields
`define ADCR_B_SRC_HI      7
`define ADCR_B_SRC_LO      6
`define ADCR_B_GAIN_HI     5
`define ADCR_B_DIV_HI      2
// reset value and default conversion cycles
`define ADCR_CTRL_RESET    8'h00
`define ADCR_CONV_CYCLES   16
`endif

// >>> hw/adcr_pkg.sv
package adcr_pkg;
    // control a/b layout as stored
    typedef struct packed {
        logic       start;
        logic       busy;
        logic       enable;
        logic       align;
        logic       gain_lo;
        logic [2:0] chan;
    } adcr_ctrl_a_s;
    typedef struct packed {
        logic [1:0] src;
        logic       gain_hi;
        logic [1:0] vref_sel;
        logic [2:0] div;
    } adcr_ctrl_b_s;
    // analog side controls
    typedef struct packed {
        logic       power_on;
        logic       sample;
        logic [1:0] src;
        logic [1:0] gain;
        logic [1:0] vref_sel;
        logic [3:0] pin_analog;
    } adcr_analog_s;
    // converter states
    typedef enum logic [1:0] {
        ADCR_IDLE,
        ADCR_CONV,
        ADCR_LATCH
    } adcr_state_e;
endpackage

// >>> testbench/adcr_core_model.sv
`timescale 1ns/1ps
module adcr_core_model
    import adcr_pkg::*;
(
    input  wire logic       clk_i,
    input  adcr_analog_s    analog_i,
    input  wire logic [3:0] pin_select_i,
    output logic      [9:0] core_data_o
);
    logic [9:0] level [8]; // per source level, loaded by the bench
    logic [2:0] idx;       // internal sources 5..7, pins 0..3
    assign idx = analog_i.src != 2'h0 ? {1'b1, analog_i.src}
        : {1'b0, |pin_select_i[3:2], pin_select_i[3] | pin_select_i[1]};
    initial core_data_o = 10'h155;
    // outside sampling the value wanders, so a late latch shows up
    always @(posedge clk_i)
        core_data_o <= analog_i.sample ? level[idx] : ~core_data_o;
endmodule

// >>> testbench/adcr_ctrl_chk.sv
`timescale 1ns/1ps
module adcr_ctrl_chk
    import adcr_pkg::*;
#(
    parameter int CONV_CYCLES = 16
)(
    input logic         clk_i,
    input logic         reset_i,
    input logic         rd_i,
    input logic [7:0]   rdata_o,
    input adcr_analog_s analog_o,
    input logic [3:0]   pin_select_o,
    input logic         done_irq_o,
    input logic         conv_clk_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [8:0] ticks; // ticks since last end or power-down
    always_ff @(posedge clk_i or posedge reset_i)
        if (reset_i) ticks <= 9'h0;
        else if (done_irq_o || !analog_o.power_on) ticks <= 9'h0;
        else if (conv_clk_en_o) ticks <= ticks + 9'h1;
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata");
    a_done_pulse: assert property (done_irq_o |=> !done_irq_o) else $error("done");
    a_pin_onehot: assert property ($onehot0(pin_select_o)) else $error("pins");
    a_pin_internal: assert property (analog_o.src != 2'h0 |-> pin_select_o == 4'h0) else $error("src");
    a_tick_conv: assert property (conv_clk_en_o |-> analog_o.sample) else $error("tick");
    a_off_idle: assert property (!analog_o.power_on |-> !analog_o.sample) else $error("off");
    a_done_count: assert property (done_irq_o |-> ticks == CONV_CYCLES) else $error("count");
    a_done_power: assert property (done_irq_o |-> $past(analog_o.power_on, 2)) else $error("pwr");
    cover property (done_irq_o);
    cover property (conv_clk_en_o && analog_o.src != 2'h0);
    cover property ($past(rd_i) && rdata_o[6]);
endmodule
bind adcr_ctrl adcr_ctrl_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.clk_i, .reset_i, .rd_i,
    .rdata_o, .analog_o, .pin_select_o, .done_irq_o, .conv_clk_en_o);

// >>> testbench/adc_control_result_regs_test.sv
`timescale 1ns/1ps
module adc_control_result_regs_test;
    import adcr_pkg::*;
    logic clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, done_irq_o, conv_clk_en_o;
    logic [1:0] addr_i = 0;
    logic [7:0] wdata_i = 0, rdata_o, v, a, b;
    logic [9:0] core_data_i, raw = 0; // raw: last stored result
    logic [3:0] pin_select_o;
    adcr_analog_s analog_o;
    int err_total = 0, comparisons = 0, n;
    logic [31:0] s = 67468;
    always #2.5 clk_i = ~clk_i;
    // short conversions keep the run brief
    adcr_ctrl #(.CONV_CYCLES(4)) DUT (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .core_data_i, .analog_o, .pin_select_o, .done_irq_o, .conv_clk_en_o);
    adcr_core_model u_core (.clk_i, .analog_i(analog_o), .pin_select_i(pin_select_o),
        .core_data_o(core_data_i));
    function automatic logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [7:0] g, e);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [1:0] ad, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= ad;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one start sequence, poll, then result and read-only checks
    task automatic conv();
        int i;
        for (i = 0; i < 8; i++) u_core.level[i] = 10'(xs());
        a = (xs() & 8'h3f) | (n % 4 == 3 ? 8'h00 : 8'h20);
        b = (xs() & 8'hf8) | 8'(1 + n % 3);
        bus(1, 2'h3, b);
        bus(1, 2'h2, a | 8'h80);
        bus(1, 2'h2, a);
        bus(0, 2'h2, 0);
        chk(v, a | {1'b0, a[5], 6'h0});
        chk({3'h0, analog_o.power_on, analog_o.src, analog_o.gain}, {3'h0, a[5], b[7:5], a[3]});
        chk({4'h0, pin_select_o}, b[7:6] == 0 && !a[2] ? 8'h1 << a[1:0] : 8'h0);
        for (i = 0; i < 400 && v[6]; i++) bus(0, 2'h2, 0);
        chk(v, a);
        if (a[5]) raw = u_core.level[b[7:6] != 0 ? {1'b1, b[7:6]} : a[2] ? 3'h0 : {1'b0, a[1:0]}];
        bus(1, 2'h0, 8'(xs()));
        bus(1, 2'h1, 8'(xs()));
        bus(0, 2'h0, 0);
        chk(v, a[4] ? raw[7:0] : {raw[1:0], 6'h0});
        bus(0, 2'h1, 0);
        chk(v, a[4] ? {6'h0, raw[9:8]} : raw[9:2]);
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        bus(0, 2'h2, 0);
        chk(v, 8'h00);
        for (n = 0; n < 24; n++) conv();
        end_of_test();
    end
endmodule
